// file: tmr2_pkg.sv
// constants for the split-capable 16-bit timer: special function addresses,
// control field positions, reset values and divider counts.
// assumes the core's byte-wide special function bus and a 20 MHz core clock.
//
// How it works
// - high flag sets when high byte wraps
// - 16-bit mode: high flag on full wrap
// - interrupt request follows high flag when enabled
// - flags cleared only by software writes
// - low flag sets on low byte wrap
// - low-byte enable adds low flag interrupts
// - bit 4 switches capture mode
// - bit 3 picks 16-bit or split
// - bit 2 runs or holds the count
// - split mode: run gates high byte only
// - bit 1 reads zero, ignores writes
// - bit 0 picks core/12 or external/8
// - external clock synchronised before use
// - split: shared select, per-byte fast override
// - control at 0xC8, bit-addressable, resets zero
// - 16-bit wrap loads reload pair
// - split: each byte reloads own byte
// - capture: falling edge copies count, sets flag
// - fast select one picks core clock
package tmr2_pkg;
    // special function addresses
    localparam logic [7:0] ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
    // bit addresses of the control register start at its byte address
    localparam logic [4:0] CONTROL_BIT_BASE = 5'h19;

    // control field positions
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_UNUSED = 1;
    localparam int BIT_EXT_CLOCK = 0;
    // bits that software may write; the unused bit is held at zero
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;

    // wrap points
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

    // divider counts
    localparam int CORE_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;
endpackage

// file: tmr2_sync.sv
// two-flop synchroniser for levels arriving from outside the core clock.
// assumes the input changes no faster than the core clock can sample.
`timescale 1ns/1ps
module tmr2_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } tmr2_sync_state_t;

    tmr2_sync_state_t state_reg;
    tmr2_sync_state_t state_next;

    // first stage feeds only the second stage
    always_comb
    begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign sync_out = state_reg.stable;
endmodule

// file: tmr2_tick_gen.sv
// slow tick sources: core clock divided by twelve, and the synchronised
// external oscillator divided by eight with its falling-edge capture strobe.
// assumes the external oscillator runs well below half the core clock.
`timescale 1ns/1ps
module tmr2_tick_gen #(
    parameter int CORE_DIV = tmr2_pkg::CORE_DIVIDE,
    parameter int EXT_DIV = tmr2_pkg::EXT_DIVIDE
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ext_osc_sync,
    output logic tick_core_div,
    output logic tick_ext_div,
    output logic ext_div_fall
);
    localparam int CORE_W = $clog2(CORE_DIV);
    localparam int EXT_W = $clog2(EXT_DIV / 2);
    localparam logic [CORE_W-1:0] CORE_LAST = CORE_W'(CORE_DIV - 1);
    localparam logic [EXT_W-1:0] EXT_HALF_LAST = EXT_W'(EXT_DIV / 2 - 1);

    typedef struct packed {
        logic [CORE_W-1:0] core_cnt;
        logic core_tick;
        logic osc_prev;
        logic [EXT_W-1:0] ext_cnt;
        logic ext_level;
        logic ext_rise;
        logic ext_fall;
    } tmr2_tick_state_t;

    tmr2_tick_state_t state_reg;
    tmr2_tick_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.core_tick = 1'b0;
        state_next.ext_rise = 1'b0;
        state_next.ext_fall = 1'b0;
        // one core tick in every CORE_DIV clocks
        if (state_reg.core_cnt == CORE_LAST)
        begin
            state_next.core_cnt = '0;
            state_next.core_tick = 1'b1;
        end
        else
            state_next.core_cnt = state_reg.core_cnt + 1'b1;
        // divided level toggles every half period of rising oscillator edges
        state_next.osc_prev = ext_osc_sync;
        if (ext_osc_sync && !state_reg.osc_prev)
        begin
            if (state_reg.ext_cnt == EXT_HALF_LAST)
            begin
                state_next.ext_cnt = '0;
                state_next.ext_level = !state_reg.ext_level;
                state_next.ext_rise = !state_reg.ext_level;
                state_next.ext_fall = state_reg.ext_level;
            end
            else
                state_next.ext_cnt = state_reg.ext_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign tick_core_div = state_reg.core_tick;
    assign tick_ext_div = state_reg.ext_rise;
    assign ext_div_fall = state_reg.ext_fall;
endmodule

// file: tmr2_timer.sv
// timer with control register, two count bytes and two reload bytes on the
// core's special function bus, plus the interrupt request to the core.
// assumes one bus write per cycle; fast clock selects and the timer
// interrupt enable come from registers elsewhere on the core clock.
`timescale 1ns/1ps
module tmr2_timer (
    input wire logic clock,
    input wire logic nrst,
    // byte access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_wdata,
    // bit access
    input wire logic [7:0] bit_addr,
    input wire logic bit_write,
    input wire logic bit_wdata,
    // from the shared clock control and interrupt enable registers
    input wire logic high_byte_fast_clock_select,
    input wire logic low_byte_fast_clock_select,
    input wire logic timer_irq_enable,
    // external oscillator pin
    input wire logic ext_osc,
    output logic [7:0] sfr_rdata,
    output logic irq_request
);
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic ext_clock_select;
        logic [7:0] high_count_byte;
        logic [7:0] low_count_byte;
        logic [7:0] reload_high_byte;
        logic [7:0] reload_low_byte;
        logic [7:0] rdata;
        logic irq;
    } tmr2_state_t;

    tmr2_state_t state_reg;
    tmr2_state_t state_next;

    logic ext_osc_sync;
    logic tick_core_div;
    logic tick_ext_div;
    logic ext_div_fall;

    // external oscillator is re-timed before it may advance the count
    tmr2_sync #(
        .WIDTH(1)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(ext_osc),
        .sync_out(ext_osc_sync)
    );

    tmr2_tick_gen u_ticks (
        .clock(clock),
        .nrst(nrst),
        .ext_osc_sync(ext_osc_sync),
        .tick_core_div(tick_core_div),
        .tick_ext_div(tick_ext_div),
        .ext_div_fall(ext_div_fall)
    );

    // per-byte tick: fast select overrides, else the shared slow source
    logic slow_tick;
    logic tick_high;
    logic tick_low;
    assign slow_tick = state_reg.ext_clock_select ? tick_ext_div : tick_core_div;
    assign tick_high = high_byte_fast_clock_select ? 1'b1 : slow_tick;
    assign tick_low = low_byte_fast_clock_select ? 1'b1 : slow_tick;

    // control register image as software sees it, unused bit forced low
    logic [7:0] control_image;
    always_comb
    begin
        control_image = tmr2_pkg::CONTROL_RESET;
        control_image[tmr2_pkg::BIT_HIGH_FLAG] = state_reg.high_overflow_flag;
        control_image[tmr2_pkg::BIT_LOW_FLAG] = state_reg.low_overflow_flag;
        control_image[tmr2_pkg::BIT_LOW_IRQ_EN] = state_reg.low_byte_irq_enable;
        control_image[tmr2_pkg::BIT_CAPTURE_EN] = state_reg.capture_enable;
        control_image[tmr2_pkg::BIT_SPLIT] = state_reg.split_mode_select;
        control_image[tmr2_pkg::BIT_RUN] = state_reg.run_control;
        control_image[tmr2_pkg::BIT_UNUSED] = 1'b0;
        control_image[tmr2_pkg::BIT_EXT_CLOCK] = state_reg.ext_clock_select;
    end

    // control value after a byte or bit write this cycle
    logic [7:0] control_written;
    logic bit_hit;
    logic [2:0] bit_sel;
    assign bit_hit = bit_write && (bit_addr[7:3] == tmr2_pkg::CONTROL_BIT_BASE);
    assign bit_sel = bit_addr[2:0];
    always_comb
    begin
        control_written = control_image;
        if (sfr_write && sfr_addr == tmr2_pkg::ADDR_CONTROL)
            control_written = sfr_wdata;
        if (bit_hit)
            control_written[bit_sel] = bit_wdata;
        control_written = control_written & tmr2_pkg::CONTROL_WRITE_MASK;
    end

    // hardware events of this cycle
    logic set_high;
    logic set_low;
    logic [15:0] word;
    assign word = {state_reg.high_count_byte, state_reg.low_count_byte};

    always_comb
    begin
        state_next = state_reg;
        set_high = 1'b0;
        set_low = 1'b0;

        // counting; split mode chooses two byte counters
        if (!state_reg.split_mode_select)
        begin
            if (state_reg.run_control && tick_low)
            begin
                if (state_reg.low_count_byte == tmr2_pkg::BYTE_MAX)
                    set_low = 1'b1;
                if (word == tmr2_pkg::WORD_MAX)
                begin
                    set_high = 1'b1;
                    state_next.high_count_byte = state_reg.reload_high_byte;
                    state_next.low_count_byte = state_reg.reload_low_byte;
                end
                else
                    {state_next.high_count_byte, state_next.low_count_byte} = word + 16'h0001;
            end
        end
        else
        begin
            // low byte runs regardless of the run control
            if (tick_low)
            begin
                if (state_reg.low_count_byte == tmr2_pkg::BYTE_MAX)
                begin
                    set_low = 1'b1;
                    state_next.low_count_byte = state_reg.reload_low_byte;
                end
                else
                    state_next.low_count_byte = state_reg.low_count_byte + 8'h01;
            end
            if (state_reg.run_control && tick_high)
            begin
                if (state_reg.high_count_byte == tmr2_pkg::BYTE_MAX)
                begin
                    set_high = 1'b1;
                    state_next.high_count_byte = state_reg.reload_high_byte;
                end
                else
                    state_next.high_count_byte = state_reg.high_count_byte + 8'h01;
            end
        end

        // capture copies the pre-tick count into the reload pair
        if (state_reg.capture_enable && ext_div_fall)
        begin
            state_next.reload_high_byte = state_reg.high_count_byte;
            state_next.reload_low_byte = state_reg.low_count_byte;
            set_high = 1'b1;
        end

        // software byte writes to count and reload win over counting
        if (sfr_write)
        begin
            unique case (sfr_addr)
                tmr2_pkg::ADDR_COUNT_LOW: state_next.low_count_byte = sfr_wdata;
                tmr2_pkg::ADDR_COUNT_HIGH: state_next.high_count_byte = sfr_wdata;
                tmr2_pkg::ADDR_RELOAD_LOW: state_next.reload_low_byte = sfr_wdata;
                tmr2_pkg::ADDR_RELOAD_HIGH: state_next.reload_high_byte = sfr_wdata;
                default: ;
            endcase
        end

        // control fields; flags only drop when software writes zero
        state_next.low_byte_irq_enable = control_written[tmr2_pkg::BIT_LOW_IRQ_EN];
        state_next.capture_enable = control_written[tmr2_pkg::BIT_CAPTURE_EN];
        state_next.split_mode_select = control_written[tmr2_pkg::BIT_SPLIT];
        state_next.run_control = control_written[tmr2_pkg::BIT_RUN];
        state_next.ext_clock_select = control_written[tmr2_pkg::BIT_EXT_CLOCK];
        // a set in the same cycle as a clear is kept
        state_next.high_overflow_flag =
            control_written[tmr2_pkg::BIT_HIGH_FLAG] | set_high;
        state_next.low_overflow_flag =
            control_written[tmr2_pkg::BIT_LOW_FLAG] | set_low;

        // interrupt request is a level held while a qualifying flag stands
        state_next.irq = timer_irq_enable &&
            (state_next.high_overflow_flag ||
             (state_next.low_byte_irq_enable && state_next.low_overflow_flag));

        // read data is registered, one cycle after the address
        unique case (sfr_addr)
            tmr2_pkg::ADDR_CONTROL: state_next.rdata = control_image;
            tmr2_pkg::ADDR_COUNT_LOW: state_next.rdata = state_reg.low_count_byte;
            tmr2_pkg::ADDR_COUNT_HIGH: state_next.rdata = state_reg.high_count_byte;
            tmr2_pkg::ADDR_RELOAD_LOW: state_next.rdata = state_reg.reload_low_byte;
            tmr2_pkg::ADDR_RELOAD_HIGH: state_next.rdata = state_reg.reload_high_byte;
            default: state_next.rdata = 8'h00;
        endcase
    end

    // everything returns to zero on reset
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= '0;
        end
        else
            state_reg <= state_next;
    end

    assign sfr_rdata = state_reg.rdata;
    assign irq_request = state_reg.irq;
endmodule

// file: tmr2_timer_properties.sv
// concurrent checks on the timer's read-back path and interrupt request.
// assumes it is bound to tmr2_timer and sees only that module's ports.
`timescale 1ns/1ps
module tmr2_timer_properties (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] bit_addr,
    input wire logic bit_write,
    input wire logic bit_wdata,
    input wire logic high_byte_fast_clock_select,
    input wire logic low_byte_fast_clock_select,
    input wire logic timer_irq_enable,
    input wire logic ext_osc,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_request
);
    logic ctl_wr;

    // any software write reaching the control register, byte or bit
    assign ctl_wr = (sfr_write && sfr_addr == tmr2_pkg::ADDR_CONTROL)
        || (bit_write && bit_addr[7:3] == tmr2_pkg::CONTROL_BIT_BASE);

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // reset check must not be switched off by the reset it watches
    a_reset_clears_outputs: assert property (
        disable iff (1'b0) !nrst |=> sfr_rdata == 8'h00 && !irq_request)
        else $error("outputs not cleared by reset");
    a_unused_bit_zero: assert property (
        $past(sfr_addr) == 8'hC8 |-> !sfr_rdata[1])
        else $error("unused control bit reads one");
    a_unmapped_reads_zero: assert property (
        !($past(sfr_addr) inside {8'hC8, [8'hCA:8'hCD]}) |-> sfr_rdata == 8'h00)
        else $error("unmapped address returns data");
    a_irq_needs_enable: assert property (
        !timer_irq_enable [*2] |-> !irq_request)
        else $error("interrupt request while disabled");
    a_control_write_back: assert property (
        (sfr_write && sfr_addr == 8'hC8 && !bit_write) ##1 (sfr_addr == 8'hC8 && !ctl_wr)
        |=> (sfr_rdata & 8'h3F) == ($past(sfr_wdata, 2) & tmr2_pkg::CONTROL_WRITE_MASK & 8'h3F))
        else $error("control byte write not read back");
    a_run_bit_write: assert property (
        (bit_write && bit_addr == 8'hCA && !sfr_write) ##1 (sfr_addr == 8'hC8 && !ctl_wr)
        |=> sfr_rdata[tmr2_pkg::BIT_RUN] == $past(bit_wdata, 2))
        else $error("run bit write not read back");
    a_flags_stay_set: assert property (
        (sfr_addr == 8'hC8 && !ctl_wr) [*3]
        |=> (sfr_rdata[7:6] & $past(sfr_rdata[7:6])) == $past(sfr_rdata[7:6]))
        else $error("overflow flag cleared without software");
    a_irq_level_holds: assert property (
        (timer_irq_enable && !ctl_wr) [*2] ##0 irq_request |=> irq_request)
        else $error("interrupt request dropped with flag standing");
endmodule

bind tmr2_timer tmr2_timer_properties u_props (
    .clock(clock),
    .nrst(nrst),
    .sfr_addr(sfr_addr),
    .sfr_write(sfr_write),
    .sfr_wdata(sfr_wdata),
    .bit_addr(bit_addr),
    .bit_write(bit_write),
    .bit_wdata(bit_wdata),
    .high_byte_fast_clock_select(high_byte_fast_clock_select),
    .low_byte_fast_clock_select(low_byte_fast_clock_select),
    .timer_irq_enable(timer_irq_enable),
    .ext_osc(ext_osc),
    .sfr_rdata(sfr_rdata),
    .irq_request(irq_request)
);

// file: tb.sv
// self-checking bench for the timer: register tasks and timed runs.
// assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_write = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] bit_addr = 8'h00;
    logic bit_write = 1'b0;
    logic bit_wdata = 1'b0;
    logic hi_fast = 1'b0;
    logic lo_fast = 1'b0;
    logic irq_en = 1'b0;
    logic osc_on = 1'b0;
    logic [2:0] osc_div = 3'h0;
    logic [7:0] sfr_rdata;
    logic irq_request;
    logic [7:0] v;
    logic [7:0] addrs [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h55};
    logic [7:0] wvals [3] = '{8'h02, 8'h39, 8'h1C};
    int err_count = 0;
    int total_checks = 0;

    always #25 clock = ~clock;
    // oscillator pin at one eighth of the core clock, held still when off
    always @(posedge clock)
        if (osc_on) osc_div <= osc_div + 3'h1;

    tmr2_timer DUT (
        .clock(clock),
        .nrst(nrst),
        .sfr_addr(sfr_addr),
        .sfr_write(sfr_write),
        .sfr_wdata(sfr_wdata),
        .bit_addr(bit_addr),
        .bit_write(bit_write),
        .bit_wdata(bit_wdata),
        .high_byte_fast_clock_select(hi_fast),
        .low_byte_fast_clock_select(lo_fast),
        .timer_irq_enable(irq_en),
        .ext_osc(osc_div[2]),
        .sfr_rdata(sfr_rdata),
        .irq_request(irq_request)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // byte write: one cycle pulse, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_write <= 1'b1;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_write <= 1'b0;
    endtask

    task automatic bw(input logic [7:0] n, input logic d);
        @(posedge clock);
        bit_addr <= 8'hC8 + n;
        bit_write <= 1'b1;
        bit_wdata <= d;
        @(posedge clock);
        bit_write <= 1'b0;
    endtask

    // read data is launched at the edge after the address; taken at the
    // following edge before it moves, so the next stimulus stays on an edge
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        sfr_addr <= a;
        @(posedge clock);
        @(posedge clock);
        v = sfr_rdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(v, e);
    endtask

    task automatic ci(input logic e);
        @(posedge clock);
        @(posedge clock);
        chk({7'h00, irq_request}, {7'h00, e});
    endtask

    // run the timer for a number of cycles, then stop it by bit write
    task automatic run_for(input int n);
        bw(8'h02, 1'b1);
        repeat (n) @(posedge clock);
        bw(8'h02, 1'b0);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        foreach (addrs[i]) rc(addrs[i], 8'h00);
        // mode, capture, run and clock bits; bit 1 must stay zero
        foreach (wvals[i])
        begin
            wr(8'hC8, wvals[i]);
            rc(8'hC8, wvals[i] & 8'hFD);
        end
        bw(8'h01, 1'b1);
        rc(8'hC8, 8'h1C);
        wr(8'hC8, 8'h00);
        lo_fast <= 1'b1;
        irq_en <= 1'b1;
        wr(8'hCB, 8'h12);
        wr(8'hCA, 8'h34);
        wr(8'hCD, 8'h00);
        wr(8'hCC, 8'hFE);
        run_for(6);
        rc(8'hC8, 8'h40);
        ci(1'b0);
        bw(8'h05, 1'b1);
        ci(1'b1);
        bw(8'h06, 1'b0);
        ci(1'b0);
        wr(8'hCD, 8'hFF);
        wr(8'hCC, 8'hFE);
        run_for(6);
        rc(8'hCD, 8'h12);
        ci(1'b1);
        repeat (20) @(posedge clock);
        rc(8'hC8, 8'hE0);
        // with the timer interrupt off the request drops, flags standing
        irq_en <= 1'b0;
        ci(1'b0);
        irq_en <= 1'b1;
        ci(1'b1);
        // eight ticks from 0xFFFE end at 0x123A; run off then holds it
        rc(8'hCC, 8'h3A);
        repeat (20) @(posedge clock);
        rc(8'hCC, 8'h3A);
        // split: low byte counts with run off, high byte holds
        wr(8'hCA, 8'h80);
        wr(8'hCD, 8'h50);
        wr(8'hCC, 8'hFE);
        wr(8'hC8, 8'h08);
        repeat (6) @(posedge clock);
        rc(8'hCD, 8'h50);
        rc(8'hC8, 8'h48);
        rd(8'hCC);
        chk({7'h00, v[7]}, 8'h01);
        hi_fast <= 1'b1;
        wr(8'hCD, 8'hFE);
        run_for(6);
        rc(8'hC8, 8'hC8);
        rd(8'hCD);
        chk({7'h00, v[7]}, 8'h00);
        // low byte wraps at the very edge that takes the flag clear
        wr(8'hCC, 8'hFE);
        bw(8'h06, 1'b0);
        rc(8'hC8, 8'hC8);
        // slow clocks: core divided by twelve, then oscillator by eight
        hi_fast <= 1'b0;
        lo_fast <= 1'b0;
        wr(8'hC8, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hCC, 8'h00);
        run_for(119);
        rd(8'hCC);
        chk(8'(v inside {[8'h09:8'h0B]}), 8'h01);
        osc_on <= 1'b1;
        wr(8'hCC, 8'h00);
        bw(8'h00, 1'b1);
        run_for(640);
        rd(8'hCC);
        chk(8'(v inside {[8'h09:8'h0B]}), 8'h01);
        // capture copies the running count into the reload pair
        lo_fast <= 1'b1;
        wr(8'hCB, 8'h00);
        wr(8'hCD, 8'h10);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h14);
        repeat (100) @(posedge clock);
        bw(8'h02, 1'b0);
        rc(8'hC8, 8'h90);
        rc(8'hCB, 8'h10);
        close_out();
    end
endmodule
